// ===== design/tdma_link_if.sv
interface tdma_link_if;
   // scheduler to units
   logic grant;
   logic [15:0] grant_id;
   logic req_win;
   logic gps_valid;
   logic [15:0] gps_src;
   logic [15:0] gps_dst;
   logic [31:0] gps_data;
   // units to scheduler
   logic rsp_valid;
   logic [1:0] rsp_kind;
   logic [15:0] rsp_id;
   logic [31:0] rsp_data;

   modport sched (
      output grant, grant_id, req_win, gps_valid, gps_src, gps_dst,
      output gps_data,
      input rsp_valid, rsp_kind, rsp_id, rsp_data
   );
   modport unit (
      input grant, grant_id, req_win, gps_valid, gps_src, gps_dst,
      input gps_data,
      output rsp_valid, rsp_kind, rsp_id, rsp_data
   );
endinterface

// ===== design/tdma_pkg.sv
package tdma_pkg;
   // timebase
   localparam int unsigned CLK_HZ = 40_000_000;
   localparam int unsigned MS_PER_S = 1000;
   localparam int unsigned CYC_PER_MS_DEF = CLK_HZ / MS_PER_S;
   // remote list
   localparam int unsigned LIST_DEPTH_DEF = 8192;
   localparam logic [15:0] LIST_ID_BASE = 16'h0002;
   localparam logic [15:0] LIST_END_ID = 16'h0000;
   localparam logic [15:0] MASTER_ID = 16'h0001;
   localparam logic [15:0] DEAD_ID = 16'hffff;
   localparam logic [15:0] BCAST_ID = 16'hffff;
   localparam logic [15:0] AGING_OFF = 16'hffff;
   // access schemes
   localparam logic [2:0] SCH_STD = 3'h1;
   localparam logic [2:0] SCH_GPS = 3'h3;
   localparam logic [2:0] SCH_ADAPT = 3'h4;
   // reset values
   localparam logic [7:0] POLL_WAIT_RST = 8'h0a;
   localparam logic [7:0] REQ_WIN_RST = 8'h01;
   localparam logic [15:0] AGING_RST = 16'h000a;
   localparam logic [2:0] HOP_SEL_RST = 3'h0;
   // register offsets
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_POLL = 8'h04;
   localparam logic [7:0] A_WIN = 8'h08;
   localparam logic [7:0] A_AGE = 8'h0c;
   localparam logic [7:0] A_HOP = 8'h10;
   localparam logic [7:0] A_UNIT = 8'h14;
   localparam logic [7:0] A_LIDX = 8'h18;
   localparam logic [7:0] A_LDAT = 8'h1c;
   localparam logic [7:0] A_STAT = 8'h20;
   localparam logic [7:0] A_RXD = 8'h24;
   localparam logic [7:0] A_RXS = 8'h28;
   localparam logic [7:0] A_TXD = 8'h2c;
   // fields
   localparam int unsigned CTRL_EN_BIT = 3;
   localparam int unsigned STAT_RXNEW_BIT = 10;
   localparam logic [2:0] SIZE_WORD = 3'h2;

   typedef enum logic [1:0] {
      RSP_DATA = 2'h0,
      RSP_DONE = 2'h1,
      RSP_NODATA = 2'h2,
      RSP_REQ = 2'h3
   } rsp_kind_e;

   // hop interval in ms from hop_period_setting
   function automatic logic [7:0] hop_ms(input logic [2:0] c);
      case (c)
         3'h0: hop_ms = 8'd200;
         3'h1: hop_ms = 8'd100;
         3'h2: hop_ms = 8'd50;
         3'h3: hop_ms = 8'd25;
         3'h4: hop_ms = 8'd20;
         3'h5: hop_ms = 8'd10;
         3'h6: hop_ms = 8'd5;
         default: hop_ms = 8'd200;
      endcase
   endfunction

   // slots in a one second frame
   function automatic logic [7:0] gps_slots(input logic [2:0] c);
      gps_slots = 8'(MS_PER_S / 32'(hop_ms(c)));
   endfunction
endpackage

// ===== design/tdma_sched.sv
module tdma_sched
   import tdma_pkg::*;
#(
   parameter int unsigned LIST_DEPTH = LIST_DEPTH_DEF,
   parameter int unsigned CYC_PER_MS = CYC_PER_MS_DEF
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   // gps pulse per second
   input wire logic pps,
   // radio link
   tdma_link_if.sched link
);
   localparam int unsigned IW = $clog2(LIST_DEPTH);

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_POLL = 4'b0010,
      ST_WIN = 4'b0100,
      ST_GPS = 4'b1000
   } state_e;

   state_e state_ff;
   logic en_ff, ready_ff, wr_ff, rx_new_ff, tx_pend_ff;
   logic [2:0] scheme_ff, hop_sel_ff;
   logic [7:0] poll_wait_ff, req_win_ff, quiet_ff, win_cnt_ff, slot_ff;
   logic [15:0] aging_ff, unit_id_ff, dest_id_ff, rx_src_ff;
   logic [IW-1:0] list_idx_ff, idx_ff;
   logic [IW:0] adp_len_ff;
   logic [7:0] wr_addr_ff;
   logic [31:0] rdata_ff, rx_word_ff, tx_word_ff;
   logic [15:0] list_ff [LIST_DEPTH];
   logic [15:0] age_ff [LIST_DEPTH];
   logic got_end_ff, got_data_ff, talking_ff;
   logic [23:0] hop_cnt_ff;
   logic pps_d_ff, seen_pps_ff;
   logic grant_ff, win_open_ff, gps_valid_ff;
   logic [15:0] grant_id_ff;
   logic [31:0] gps_data_ff;

   logic adaptive, hop_tick, pps_rise, rsp_cur, wrap, adv, timeout;
   logic skip_cur, age_hit, in_slot, start_adapt, bus_take;
   logic [23:0] hop_cyc;
   logic [7:0] slots;
   logic [15:0] cur_id, tgt_id;
   logic [IW:0] nxt_idx;
   logic [IW-1:0] tgt_idx;
   logic [31:0] rd_mux;

   // entry that can be granted on the link
   function automatic logic id_live(input logic [15:0] id,
                                    input logic adp);
      id_live = id != LIST_END_ID && id != DEAD_ID &&
         !(adp && id == MASTER_ID);
   endfunction

   assign adaptive = scheme_ff == SCH_ADAPT;
   assign hop_cyc = 24'(32'(hop_ms(hop_sel_ff)) * CYC_PER_MS);
   assign hop_tick = hop_cnt_ff == hop_cyc - 24'h1;
   assign pps_rise = pps && !pps_d_ff;
   assign cur_id = list_ff[idx_ff];
   assign rsp_cur = link.rsp_valid && link.rsp_id == cur_id;
   assign nxt_idx = {1'b0, idx_ff} + {{IW{1'b0}}, 1'b1};
   assign wrap = adaptive ? (nxt_idx >= adp_len_ff) :
      (nxt_idx == (IW+1)'(LIST_DEPTH) ||
       list_ff[nxt_idx[IW-1:0]] == LIST_END_ID);
   assign tgt_idx = wrap ? '0 : nxt_idx[IW-1:0];
   assign tgt_id = list_ff[tgt_idx];
   assign skip_cur = !id_live(cur_id, adaptive);
   assign timeout = !got_data_ff && (quiet_ff + 8'h1 >= poll_wait_ff);
   assign adv = got_end_ff || skip_cur || timeout;
   assign age_hit = adaptive && timeout && !talking_ff && !skip_cur &&
      !got_end_ff && aging_ff != AGING_OFF;
   assign start_adapt = state_ff == ST_IDLE && en_ff && adaptive;
   assign slots = gps_slots(hop_sel_ff);
   assign in_slot = state_ff == ST_GPS && seen_pps_ff &&
      unit_id_ff != 16'h0 && unit_id_ff <= {8'h0, slots} &&
      slot_ff == 8'(unit_id_ff - 16'h1);
   assign bus_take = hsel && hready && htrans[1];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hop_cnt_ff <= 24'h0;
      end else if (hop_tick || (pps_rise && state_ff == ST_GPS)) begin
         hop_cnt_ff <= 24'h0;
      end else begin
         hop_cnt_ff <= hop_cnt_ff + 24'h1;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= ST_IDLE;
         idx_ff <= '0;
         quiet_ff <= 8'h0;
         win_cnt_ff <= 8'h0;
         talking_ff <= 1'b0;
         grant_ff <= 1'b0;
         grant_id_ff <= 16'h0;
         win_open_ff <= 1'b0;
      end else if (!en_ff) begin
         state_ff <= ST_IDLE;
         grant_ff <= 1'b0;
         win_open_ff <= 1'b0;
      end else begin
         grant_ff <= 1'b0;
         case (state_ff)
            ST_IDLE: begin
               idx_ff <= '0;
               quiet_ff <= 8'h0;
               talking_ff <= 1'b0;
               if (scheme_ff == SCH_STD || adaptive) begin
                  state_ff <= ST_POLL;
               end else if (scheme_ff == SCH_GPS) begin
                  state_ff <= ST_GPS;
               end
            end
            ST_POLL: begin
               if (hop_tick && adv) begin
                  quiet_ff <= 8'h0;
                  talking_ff <= 1'b0;
                  idx_ff <= tgt_idx;
                  if (wrap && adaptive) begin
                     state_ff <= ST_WIN;
                     win_cnt_ff <= 8'h0;
                     win_open_ff <= 1'b1;
                  end else if (id_live(tgt_id, adaptive)) begin
                     grant_ff <= 1'b1;
                     grant_id_ff <= tgt_id;
                  end
               end else if (hop_tick) begin
                  quiet_ff <= got_data_ff ? 8'h0 : quiet_ff + 8'h1;
                  if (!got_data_ff && !talking_ff) begin
                     grant_ff <= 1'b1;
                     grant_id_ff <= cur_id;
                  end
               end else if (rsp_cur && link.rsp_kind == RSP_DATA) begin
                  talking_ff <= 1'b1;
               end
            end
            ST_WIN: begin
               if (hop_tick) begin
                  win_cnt_ff <= win_cnt_ff + 8'h1;
                  if (win_cnt_ff + 8'h1 >= req_win_ff) begin
                     state_ff <= ST_POLL;
                     win_open_ff <= 1'b0;
                  end
               end
            end
            ST_GPS: begin
            end
            default: state_ff <= ST_IDLE;
         endcase
      end
   end

   // answers seen during the current hop
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         got_end_ff <= 1'b0;
         got_data_ff <= 1'b0;
      end else begin
         if (rsp_cur && (link.rsp_kind == RSP_DONE ||
                         link.rsp_kind == RSP_NODATA)) begin
            got_end_ff <= 1'b1;
         end else if (hop_tick) begin
            got_end_ff <= 1'b0;
         end
         if (rsp_cur && link.rsp_kind == RSP_DATA) begin
            got_data_ff <= 1'b1;
         end else if (hop_tick) begin
            got_data_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         for (int i = 0; i < LIST_DEPTH; i++) begin
            list_ff[i] <= 16'(i) + LIST_ID_BASE;
            age_ff[i] <= AGING_RST;
         end
         adp_len_ff <= (IW+1)'(1);
      end else if (start_adapt) begin
         list_ff[0] <= MASTER_ID;
         adp_len_ff <= (IW+1)'(1);
      end else if (wr_ff && wr_addr_ff == A_LDAT) begin
         list_ff[list_idx_ff] <= hwdata[15:0];
      end else begin
         if (state_ff == ST_WIN && link.rsp_valid &&
             link.rsp_kind == RSP_REQ && id_live(link.rsp_id, 1'b1) &&
             adp_len_ff < (IW+1)'(LIST_DEPTH)) begin
            list_ff[adp_len_ff[IW-1:0]] <= link.rsp_id;
            age_ff[adp_len_ff[IW-1:0]] <= aging_ff;
            adp_len_ff <= adp_len_ff + (IW+1)'(1);
         end
         // age on silence, reload on any answer from the current unit
         if (state_ff == ST_POLL && hop_tick && age_hit) begin
            if (age_ff[idx_ff] <= 16'h1) begin
               list_ff[idx_ff] <= DEAD_ID;
               age_ff[idx_ff] <= 16'h0;
            end else begin
               age_ff[idx_ff] <= age_ff[idx_ff] - 16'h1;
            end
         end else if (rsp_cur && adaptive) begin
            age_ff[idx_ff] <= aging_ff;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pps_d_ff <= 1'b0;
         seen_pps_ff <= 1'b0;
         slot_ff <= 8'h0;
         gps_valid_ff <= 1'b0;
         gps_data_ff <= 32'h0;
      end else begin
         pps_d_ff <= pps;
         if (pps_rise) begin
            seen_pps_ff <= 1'b1;
            slot_ff <= 8'h0;
         end else if (hop_tick && slot_ff < slots) begin
            slot_ff <= slot_ff + 8'h1;
         end
         gps_valid_ff <= in_slot && tx_pend_ff;
         if (in_slot && tx_pend_ff) begin
            gps_data_ff <= tx_word_ff;
         end
      end
   end

   always_comb begin
      case (haddr[7:0])
         A_CTRL: rd_mux = {28'h0, en_ff, scheme_ff};
         A_POLL: rd_mux = {24'h0, poll_wait_ff};
         A_WIN: rd_mux = {24'h0, req_win_ff};
         A_AGE: rd_mux = {16'h0, aging_ff};
         A_HOP: rd_mux = {29'h0, hop_sel_ff};
         A_UNIT: rd_mux = {dest_id_ff, unit_id_ff};
         A_LIDX: rd_mux = 32'(list_idx_ff);
         A_LDAT: rd_mux = {16'h0, list_ff[list_idx_ff]};
         A_STAT: rd_mux = {cur_id, state_ff, tx_pend_ff, rx_new_ff,
                           seen_pps_ff, talking_ff, slot_ff};
         A_RXD: rd_mux = rx_word_ff;
         A_RXS: rd_mux = {16'h0, rx_src_ff};
         A_TXD: rd_mux = tx_word_ff;
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ready_ff <= 1'b1;
         wr_ff <= 1'b0;
         wr_addr_ff <= 8'h0;
         rdata_ff <= 32'h0;
      end else begin
         wr_ff <= bus_take && hwrite && hsize == SIZE_WORD;
         if (bus_take) begin
            wr_addr_ff <= haddr[7:0];
            rdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         en_ff <= 1'b0;
         scheme_ff <= SCH_STD;
         poll_wait_ff <= POLL_WAIT_RST;
         req_win_ff <= REQ_WIN_RST;
         aging_ff <= AGING_RST;
         hop_sel_ff <= HOP_SEL_RST;
         unit_id_ff <= MASTER_ID;
         dest_id_ff <= BCAST_ID;
         list_idx_ff <= '0;
         tx_word_ff <= 32'h0;
      end else if (wr_ff) begin
         case (wr_addr_ff)
            A_CTRL: begin
               scheme_ff <= hwdata[2:0];
               en_ff <= hwdata[CTRL_EN_BIT];
            end
            A_POLL: poll_wait_ff <= hwdata[7:0];
            A_WIN: req_win_ff <= hwdata[7:0];
            A_AGE: aging_ff <= hwdata[15:0];
            A_HOP: hop_sel_ff <= hwdata[2:0];
            A_UNIT: {dest_id_ff, unit_id_ff} <= hwdata;
            A_LIDX: list_idx_ff <= hwdata[IW-1:0];
            A_TXD: tx_word_ff <= hwdata;
            default: begin
            end
         endcase
      end
   end

   // sticky flags, set beats clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_new_ff <= 1'b0;
         rx_word_ff <= 32'h0;
         rx_src_ff <= 16'h0;
         tx_pend_ff <= 1'b0;
      end else begin
         if (link.rsp_valid && link.rsp_kind == RSP_DATA) begin
            rx_new_ff <= 1'b1;
            rx_word_ff <= link.rsp_data;
            rx_src_ff <= link.rsp_id;
         end else if (wr_ff && wr_addr_ff == A_STAT &&
                      hwdata[STAT_RXNEW_BIT]) begin
            rx_new_ff <= 1'b0;
         end
         if (wr_ff && wr_addr_ff == A_TXD) begin
            tx_pend_ff <= 1'b1;
         end else if (in_slot) begin
            tx_pend_ff <= 1'b0;
         end
      end
   end

   assign hreadyout = ready_ff;
   assign hresp = 1'b0;
   assign hrdata = rdata_ff;
   assign link.grant = grant_ff;
   assign link.grant_id = grant_id_ff;
   assign link.req_win = win_open_ff;
   assign link.gps_valid = gps_valid_ff;
   assign link.gps_src = unit_id_ff;
   assign link.gps_dst = dest_id_ff;
   assign link.gps_data = gps_data_ff;
endmodule

// ===== design/tdma_unit.sv
module tdma_unit
   import tdma_pkg::*;
(
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // radio link
   tdma_link_if.unit link,
   // configuration
   input wire logic [15:0] unit_id,
   input wire logic [2:0] access_scheme_select,
   // transmit stream
   input wire logic tx_valid,
   input wire logic [31:0] tx_data,
   output logic tx_ready,
   // receive stream
   output logic rx_valid,
   output logic [15:0] rx_src,
   output logic [31:0] rx_data
);
   typedef enum logic [1:0] {U_IDLE = 2'b01, U_SEND = 2'b10} ustate_e;

   ustate_e state_ff;
   logic tx_ready_ff, seen_ff, win_d_ff;
   logic rsp_valid_ff;
   logic [1:0] rsp_kind_ff;
   logic [31:0] rsp_data_ff;
   logic rx_valid_ff;
   logic [15:0] rx_src_ff;
   logic [31:0] rx_data_ff;
   logic polled_me, win_rise, adaptive;

   assign adaptive = access_scheme_select == SCH_ADAPT;
   assign polled_me = link.grant && link.grant_id == unit_id &&
      (access_scheme_select == SCH_STD || adaptive);
   assign win_rise = link.req_win && !win_d_ff;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_ff <= U_IDLE;
         tx_ready_ff <= 1'b0;
         rsp_valid_ff <= 1'b0;
         rsp_kind_ff <= RSP_DATA;
         rsp_data_ff <= 32'h0;
      end else begin
         rsp_valid_ff <= 1'b0;
         case (state_ff)
            U_IDLE: begin
               if (polled_me) begin
                  if (tx_valid) begin
                     state_ff <= U_SEND;
                     tx_ready_ff <= 1'b1;
                  end else begin
                     rsp_valid_ff <= 1'b1;
                     rsp_kind_ff <= RSP_NODATA;
                  end
               end else if (win_rise && adaptive && !seen_ff) begin
                  rsp_valid_ff <= 1'b1;
                  rsp_kind_ff <= RSP_REQ;
               end
            end
            U_SEND: begin
               rsp_valid_ff <= 1'b1;
               if (tx_valid) begin
                  rsp_kind_ff <= RSP_DATA;
                  rsp_data_ff <= tx_data;
               end else begin
                  rsp_kind_ff <= RSP_DONE;
                  tx_ready_ff <= 1'b0;
                  state_ff <= U_IDLE;
               end
            end
            default: begin
               state_ff <= U_IDLE;
               tx_ready_ff <= 1'b0;
            end
         endcase
      end
   end

   // turn seen since the last request window
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         seen_ff <= 1'b0;
         win_d_ff <= 1'b0;
      end else begin
         win_d_ff <= link.req_win;
         if (polled_me) begin
            seen_ff <= 1'b1;
         end else if (win_rise) begin
            seen_ff <= 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_valid_ff <= 1'b0;
         rx_src_ff <= 16'h0;
         rx_data_ff <= 32'h0;
      end else begin
         rx_valid_ff <= link.gps_valid && link.gps_src != unit_id &&
            (link.gps_dst == unit_id || link.gps_dst == BCAST_ID);
         if (link.gps_valid) begin
            rx_src_ff <= link.gps_src;
            rx_data_ff <= link.gps_data;
         end
      end
   end

   assign tx_ready = tx_ready_ff;
   assign rx_valid = rx_valid_ff;
   assign rx_src = rx_src_ff;
   assign rx_data = rx_data_ff;
   assign link.rsp_valid = rsp_valid_ff;
   assign link.rsp_kind = rsp_kind_ff;
   assign link.rsp_id = unit_id;
   assign link.rsp_data = rsp_data_ff;
endmodule

// ===== tb/tb_tdma_slot_scheduler.sv
module tb_tdma_slot_scheduler
   import tdma_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic pps = 1'b0;
   logic tx_valid = 1'b0;
   logic win_seen = 1'b0;
   logic [31:0] haddr = '0;
   logic [31:0] hwdata = '0;
   logic [31:0] tx_data = '0;
   logic [1:0] htrans = '0;
   logic [2:0] hsize = '0;
   logic [2:0] scheme = SCH_STD;
   logic hreadyout, hresp, tx_ready, rx_valid;
   logic [15:0] rx_src, rx_s;
   logic [31:0] rx_data, rx_d;
   int rx_n = 0;
   int rx_at = 0;
   int pps_cyc = 0;
   int dt = 0;
   logic [31:0] hrdata, rd_v;
   logic [15:0] gq[$];
   logic [15:0] lst[3] = '{16'h0002, 16'h0005, 16'h0000};
   logic [15:0] exp_g[5] = '{16'h2, 16'h5, 16'h5, 16'h5, 16'h2};
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;

   tdma_link_if lnk ();
   tdma_sched #(.LIST_DEPTH(16), .CYC_PER_MS(10)) u_tdma_sched (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .pps(pps), .link(lnk));
   tdma_unit u_tdma_unit (
      .hclk(hclk), .hresetn(hresetn), .link(lnk), .unit_id(16'h0002),
      .access_scheme_select(scheme), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_valid(rx_valid),
      .rx_src(rx_src), .rx_data(rx_data));
   tdma_link_assertions chk_link (
      .hclk(hclk), .hresetn(hresetn), .grant(lnk.grant),
      .grant_id(lnk.grant_id), .req_win(lnk.req_win),
      .rsp_valid(lnk.rsp_valid), .rsp_kind(lnk.rsp_kind));

   always #12.5 hclk = ~hclk;

   task summarize();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("FAIL %0t got %h want %h", $time, got, exp);
      end
   endtask

   // one single word transfer, address then data phase
   task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      hsize <= SIZE_WORD;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd_v = hrdata;
   endtask

   task wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task rd(input logic [7:0] a, input logic [31:0] e);
      xfer(1'b0, a, 32'h0);
      chk(rd_v, e);
   endtask

   task wait_q(input int n);
      while (gq.size() < n) @(posedge hclk);
   endtask

   // grant log, window watch, one-word sender and hang guard
   always @(posedge hclk) begin
      cyc <= cyc + 1;
      if (lnk.grant === 1'b1)
         gq.push_back(lnk.grant_id);
      if (lnk.req_win === 1'b1)
         win_seen <= 1'b1;
      if (tx_valid && tx_ready === 1'b1)
         tx_valid <= 1'b0;
      if (rx_valid === 1'b1) begin
         rx_n <= rx_n + 1;
         rx_d <= rx_data;
         rx_s <= rx_src;
         rx_at <= cyc;
      end
      if (cyc == 6000) begin
         n_mismatch++;
         summarize();
      end
   end

   initial begin
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      rd(A_POLL, 32'h0000000a);
      wr(A_LIDX, 32'h3);
      rd(A_LDAT, 32'h00000005);
      rd(8'hfc, 32'h0);
      wr(A_HOP, 32'h6);
      wr(A_POLL, 32'h3);
      for (int i = 0; i < 3; i++) begin
         wr(A_LIDX, 32'(i));
         wr(A_LDAT, 32'(lst[i]));
      end
      wr(A_CTRL, 32'h9);
      wait_q(6);
      for (int i = 0; i < 5; i++)
         chk(32'(gq[i]), 32'(exp_g[i]));
      tx_data <= 32'h00005a5a;
      tx_valid <= 1'b1;
      gq.delete();
      wait_q(4);
      chk(32'(gq[2]), 32'h2);
      chk(32'(gq[3]), 32'h5);
      rd(A_RXD, 32'h00005a5a);
      rd(A_RXS, 32'h2);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      scheme <= SCH_ADAPT;
      @(posedge hclk);
      wr(A_HOP, 32'h6);
      wr(A_WIN, 32'h2);
      wr(A_CTRL, 32'hc);
      gq.delete();
      wait_q(1);
      chk(32'(gq[0]), 32'h2);
      chk(32'(win_seen), 32'h1);
      wr(A_LIDX, 32'h0);
      rd(A_LDAT, 32'h1);
      wr(A_LIDX, 32'h1);
      rd(A_LDAT, 32'h2);
      // gps frame: sender is unit 3, broadcast, 50 cycle hops
      wr(A_CTRL, 32'h0);
      wr(A_UNIT, 32'hffff0003);
      wr(A_TXD, 32'h0000c3c3);
      wr(A_CTRL, 32'hb);
      repeat (400) @(posedge hclk);
      chk(32'(rx_n), 32'h0);
      pps <= 1'b1;
      pps_cyc = cyc;
      repeat (2) @(posedge hclk);
      pps <= 1'b0;
      repeat (200) @(posedge hclk);
      chk(32'(rx_n), 32'h1);
      chk(rx_d, 32'h0000c3c3);
      chk(32'(rx_s), 32'h3);
      dt = rx_at - pps_cyc;
      // slot 3 opens two hops of 50 cycles after the pulse
      chk(32'(dt >= 100 && dt < 150), 32'h1);
      summarize();
   end
endmodule

// ===== tb/tdma_link_assertions.sv
module tdma_link_assertions
   import tdma_pkg::*;
(
   // clock and reset
   input logic hclk,
   input logic hresetn,
   // link
   input logic grant,
   input logic [15:0] grant_id,
   input logic req_win,
   input logic rsp_valid,
   input logic [1:0] rsp_kind
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   a_grant_once_hop: assert property (
      grant |=> !grant [*8]) else $error("second grant inside one hop");
   a_grant_not_end: assert property (
      grant |-> grant_id != LIST_END_ID) else $error("list end granted");
   a_master_not_polled: assert property (
      grant |-> grant_id != MASTER_ID) else $error("master granted");
   a_nodata_timing: assert property (
      rsp_valid && rsp_kind == RSP_NODATA |-> $past(grant))
      else $error("no-data answer not one cycle after grant");
   a_nodata_single: assert property (
      rsp_valid && rsp_kind == RSP_NODATA |=> !rsp_valid)
      else $error("extra answer after no-data");
   a_data_stream: assert property (
      rsp_valid && rsp_kind == RSP_DATA |-> $past(grant, 2)
      || $past(rsp_valid) && $past(rsp_kind) == RSP_DATA)
      else $error("data word out of stream");
   a_done_after_data: assert property (
      rsp_valid && rsp_kind == RSP_DONE |->
      $past(rsp_valid) && $past(rsp_kind) == RSP_DATA)
      else $error("completion without data");
   a_window_quiet: assert property (
      req_win |-> !grant) else $error("grant inside request window");

   c_grant: cover property (grant);
   c_done: cover property (rsp_valid && rsp_kind == RSP_DONE);
   c_window: cover property (req_win ##1 !req_win);
endmodule
